// ### src/prog_timer.sv
// Programmable 16-stage timer divider with an Avalon-MM control slave
//
// Operation
// R1 - The divider is a sixteen-stage binary counter fed by the oscillator or the external clock.
// R2 - The count advances only on rising edges of its clock.
// R3 - With the auto-reset strap low the counter is initialised after power-up, with it high not.
// R4 - While the external clear is high the counter is held in reset, else it runs.
// R5 - Either reset clears all divider stages at once whatever their count.
// R6 - The external clear works whether auto-reset is enabled or not.
// R7 - While any reset is active the oscillator stops and no edges reach the divider.
// R8 - Selects hi/lo give 00 8192, 01 1024, 10 256 and 11 65536.
// R9 - With the upper select high the sixteenth stage is routed out whatever the lower select.
// R10 - Upper high and lower low clock the ninth stage straight from the oscillator, dividing by 256.
// R11 - Each ratio is the true output of the matching numbered stage; the code takes 256 from the sixteenth stage with the first eight bypassed.
// R12 - While in reset the output equals the polarity select.
// R13 - In recycle mode the selected stage is passed on continuously.
// R14 - In single-cycle mode the latch clears on reset and sets after 2^(n-1) counts, flipping the output once.
// R15 - In single-cycle mode the output then stays put until a clear pulse or a mode change.
// R16 - The oscillator may be bypassed and an external clock counted instead.
// R17 - In recycle mode the output is the selected bit, inverted when polarity is high.
`timescale 1ns/1ns
`default_nettype none

module prog_timer #(
  parameter int OSC_CYCLES = prog_timer_pkg::OSC_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ext_clk,
  input  wire logic        auto_reset_dis,
  output logic             timer_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and power-up sequence

  logic [1:0] ext_sync_q;
  logic       ext_prev_q;
  logic [1:0] strap_sync_q;
  logic [2:0] por_cnt_q, por_cnt_d;
  logic       por_done_q, por_done_d;
  logic       por_active;

  always_comb
  begin
    por_cnt_d  = por_cnt_q;
    por_done_d = por_done_q;
    if (!por_done_q)
    begin
      por_cnt_d = por_cnt_q + 3'h1;
      if (por_cnt_q == 3'(prog_timer_pkg::POR_CYCLES - 1))
        por_done_d = 1'b1;
    end
  end

  // Auto-reset only while the strap is low
  assign por_active = !por_done_q && !strap_sync_q[1]; // [R3]

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_sync_q   <= 2'h0;
      ext_prev_q   <= 1'b0;
      strap_sync_q <= 2'h0;
      por_cnt_q    <= 3'h0;
      por_done_q   <= 1'b0;
    end
    else if (ce)
    begin
      ext_sync_q   <= {ext_sync_q[0], ext_clk};
      ext_prev_q   <= ext_sync_q[1];
      strap_sync_q <= {strap_sync_q[0], auto_reset_dis};
      por_cnt_q    <= por_cnt_d;
      por_done_q   <= por_done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register slave

  prog_timer_pkg::ctrl_s      ctrl_q, ctrl_d;
  prog_timer_pkg::bus_state_e bus_q, bus_d;
  logic [31:0]                rdata_q, rdata_d;
  logic                       wait_q, wait_d;
  logic [15:0]                cnt_q, cnt_d;
  logic                       latch_q, latch_d;
  logic                       out_q, out_d;
  logic                       rst_active;

  always_comb
  begin
    bus_d   = bus_q;
    ctrl_d  = ctrl_q;
    rdata_d = rdata_q;
    wait_d  = wait_q;
    unique case (bus_q)
      prog_timer_pkg::BUS_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          bus_d  = prog_timer_pkg::BUS_ACK;
          wait_d = 1'b0;
          rdata_d = 32'h0;
          if (avs_read)
            unique case (avs_address)
              prog_timer_pkg::OFS_CTRL:
                rdata_d = {26'h0, ctrl_q};
              prog_timer_pkg::OFS_STATUS:
              begin
                rdata_d[prog_timer_pkg::STAT_OUT]   = out_q;
                rdata_d[prog_timer_pkg::STAT_LATCH] = latch_q;
                rdata_d[prog_timer_pkg::STAT_RESET] = rst_active;
                rdata_d[prog_timer_pkg::STAT_POR]   = por_active;
              end
              prog_timer_pkg::OFS_COUNT:
                rdata_d = {16'h0, cnt_q};
              default:
                rdata_d = 32'h0;
            endcase
        end
      end
      prog_timer_pkg::BUS_ACK:
      begin
        bus_d  = prog_timer_pkg::BUS_IDLE;
        wait_d = 1'b1;
        if (avs_write && avs_byteenable[0] &&
            avs_address == prog_timer_pkg::OFS_CTRL)
          ctrl_d = prog_timer_pkg::ctrl_s'(
                     avs_writedata[prog_timer_pkg::CTRL_W-1:0]);
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_q   <= prog_timer_pkg::BUS_IDLE;
      ctrl_q  <= prog_timer_pkg::CTRL_RESET;
      rdata_q <= 32'h0;
      wait_q  <= 1'b1;
    end
    else if (ce)
    begin
      bus_q   <= bus_d;
      ctrl_q  <= ctrl_d;
      rdata_q <= rdata_d;
      wait_q  <= wait_d;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator, divider and output logic

  function automatic logic [3:0] tap_of(input logic hi, input logic lo);
    if (hi)
      tap_of = prog_timer_pkg::TAP_N16;
    else if (lo)
      tap_of = prog_timer_pkg::TAP_N10;
    else
      tap_of = prog_timer_pkg::TAP_N13;
  endfunction : tap_of

  logic [15:0] osc_cnt_q, osc_cnt_d;
  logic        mode_prev_q;
  logic        tick;
  logic        osc_tick;
  logic        ext_tick;
  logic        bypass;
  logic        sel_bit;
  logic [3:0]  tap;

  // Clear acts on its own, beside the power-up reset
  assign rst_active = por_active || ctrl_q.external_clear; // [R4] [R6]
  assign osc_tick   = !ctrl_q.ext_clk_sel &&
                      osc_cnt_q == 16'(OSC_CYCLES - 1);
  assign ext_tick   = ctrl_q.ext_clk_sel && ext_sync_q[1] && !ext_prev_q; // [R2] [R16]
  assign tick       = !rst_active && (osc_tick || ext_tick); // [R7]
  assign bypass     = ctrl_q.sel_hi && !ctrl_q.sel_lo;
  assign tap        = tap_of(ctrl_q.sel_hi, ctrl_q.sel_lo); // [R8] [R9] [R11]

  always_comb
  begin
    osc_cnt_d = osc_cnt_q;
    cnt_d     = cnt_q;
    latch_d   = latch_q;
    sel_bit   = cnt_q[tap];
    if (rst_active || ctrl_q.ext_clk_sel || osc_tick)
      osc_cnt_d = 16'h0; // [R7]
    else
      osc_cnt_d = osc_cnt_q + 16'h1;
    if (rst_active)
    begin
      cnt_d   = 16'h0; // [R5]
      latch_d = 1'b0;  // [R14]
    end
    else
    begin
      if (tick)
      begin
        if (bypass)
          cnt_d[15:prog_timer_pkg::BYPASS_STAGE] =
            cnt_q[15:prog_timer_pkg::BYPASS_STAGE] + 8'h1; // [R10]
        else
          cnt_d = cnt_q + 16'h1; // [R1]
      end
      // Latch sets on the first rise of the tap and then holds
      // A rise beside a mode change still sets it
      if (!ctrl_q.recycle && cnt_d[tap] && !sel_bit)
        latch_d = 1'b1; // [R14] [R15]
      else if (ctrl_q.recycle != mode_prev_q)
        latch_d = 1'b0; // [R15]
    end
    if (rst_active)
      out_d = ctrl_q.polarity; // [R12]
    else if (ctrl_q.recycle)
      out_d = ctrl_q.polarity ^ sel_bit; // [R13] [R17]
    else
      out_d = ctrl_q.polarity ^ latch_q; // [R14]
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_cnt_q   <= 16'h0;
      cnt_q       <= 16'h0;
      latch_q     <= 1'b0;
      out_q       <= 1'b0;
      mode_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      osc_cnt_q   <= osc_cnt_d;
      cnt_q       <= cnt_d;
      latch_q     <= latch_d;
      out_q       <= out_d;
      mode_prev_q <= ctrl_q.recycle;
    end
  end

  assign timer_out = out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  chk_full_count: assert property ( // [R1]
    @(posedge core_clk) disable iff (!rstn)
    ce && tick && !bypass && !rst_active |=> cnt_q == $past(cnt_q) + 16'h1)
    else $error("divider did not advance by one");

  chk_edge_only: assert property ( // [R2]
    @(posedge core_clk) disable iff (!rstn)
    ce && !tick && !rst_active |=> cnt_q == $past(cnt_q))
    else $error("divider moved without a clock edge");

  chk_por_hold: assert property ( // [R3]
    @(posedge core_clk) disable iff (!rstn)
    ce && !por_done_q && !strap_sync_q[1] |=>
      cnt_q == 16'h0 && timer_out == $past(ctrl_q.polarity))
    else $error("power-up reset not applied");

  chk_clear_hold: assert property ( // [R4]
    @(posedge core_clk) disable iff (!rstn)
    ce && ctrl_q.external_clear |=> cnt_q == 16'h0 && latch_q == 1'b0)
    else $error("clear did not hold the divider");

  chk_reset_all: assert property ( // [R5]
    @(posedge core_clk) disable iff (!rstn)
    ce && rst_active |=> cnt_q == 16'h0)
    else $error("reset left stages set");

  chk_osc_stop: assert property ( // [R7]
    @(posedge core_clk) disable iff (!rstn)
    ce && rst_active |=> osc_cnt_q == 16'h0)
    else $error("oscillator ran during reset");

  chk_bypass_low: assert property ( // [R10]
    @(posedge core_clk) disable iff (!rstn)
    ce && bypass && !rst_active |=> cnt_q[7:0] == $past(cnt_q[7:0]))
    else $error("low stages moved in bypass");

  chk_reset_level: assert property ( // [R12]
    @(posedge core_clk) disable iff (!rstn)
    ce && rst_active |=> timer_out == $past(ctrl_q.polarity))
    else $error("output not at polarity in reset");

  chk_recycle_out: assert property ( // [R17]
    @(posedge core_clk) disable iff (!rstn)
    ce && !rst_active && ctrl_q.recycle |=>
      timer_out == ($past(ctrl_q.polarity) ^ $past(cnt_q[tap])))
    else $error("recycle output wrong");

  chk_single_hold: assert property ( // [R15]
    @(posedge core_clk) disable iff (!rstn)
    ce && latch_q && !rst_active && !ctrl_q.recycle &&
      mode_prev_q == ctrl_q.recycle |=> latch_q)
    else $error("single-cycle latch fell back");

endmodule : prog_timer

`default_nettype wire

// ### src/prog_timer_pkg.sv
// Package of constants and types for the programmable timer divider
package prog_timer_pkg;

  localparam int          CLK_PERIOD_NS = 20;
  localparam int          OSC_PERIOD_NS = 10000;
  localparam int          OSC_CYCLES    = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int          POR_CYCLES    = 4;
  localparam int          STAGES        = 16;
  localparam int          BYPASS_STAGE  = 8;

  localparam logic [3:0]  OFS_CTRL      = 4'h0;
  localparam logic [3:0]  OFS_STATUS    = 4'h4;
  localparam logic [3:0]  OFS_COUNT     = 4'h8;

  localparam int          CTRL_W        = 6;
  localparam int          STAT_OUT      = 0;
  localparam int          STAT_LATCH    = 1;
  localparam int          STAT_RESET    = 2;
  localparam int          STAT_POR      = 3;

  localparam logic [3:0]  TAP_N13       = 4'hC;
  localparam logic [3:0]  TAP_N10       = 4'h9;
  localparam logic [3:0]  TAP_N16       = 4'hF;

  typedef struct packed {
    logic ext_clk_sel;
    logic external_clear;
    logic recycle;
    logic polarity;
    logic sel_hi;
    logic sel_lo;
  } ctrl_s;

  localparam ctrl_s       CTRL_RESET    = '{default: 1'b0};

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;

endpackage : prog_timer_pkg

// ### test/ctrl_pins.sv
// Partner model: static control straps and external count clock
`timescale 1ns/1ns
`default_nettype none
module ctrl_pins (
  input  wire logic core_clk,
  input  wire logic run,
  input  wire logic strap,
  output logic      ext_clk,
  output logic      auto_reset_dis
);
  logic ph_q;
  assign auto_reset_dis = strap;
  // Clock stands low outside a run, period four core cycles
  always_ff @(posedge core_clk)
  begin
    ph_q    <= run & ~ph_q;
    ext_clk <= run & (ext_clk ^ ph_q);
  end
endmodule : ctrl_pins
`default_nettype wire

// ### test/tb.sv
// Self-checking testbench for the programmable timer divider
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam int OSC = 2;
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic        run = 1'b0;
  logic        ce = 1'b1;
  logic        strap = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] rd;
  logic [31:0] lfsr = 32'h0001494C;
  logic        avs_waitrequest;
  logic        ext_clk;
  logic        auto_reset_dis;
  logic        timer_out;
  logic [5:0]  ctrl_m = 6'h00;
  int          failures = 0;
  int          cmp_count = 0;
  int          n;
  int          p;

  always #10 core_clk = ~core_clk;

  prog_timer #(.OSC_CYCLES(OSC)) prog_timer_inst (
    .core_clk(core_clk), .rstn(rstn), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_clk(ext_clk),
    .auto_reset_dis(auto_reset_dis), .timer_out(timer_out));
  ctrl_pins ctrl_pins_inst (.core_clk(core_clk), .run(run),
    .strap(strap), .ext_clk(ext_clk), .auto_reset_dis(auto_reset_dis));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr_next

  function automatic int ratio(input int s);
    case (s)
      0: return 8192;
      1: return 1024;
      2: return 256;
      default: return 65536;
    endcase
  endfunction : ratio

  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    avs_write     <= wr;
    avs_read      <= ~wr;
    avs_address   <= a;
    avs_writedata <= d;
    // Only the watchdog ends a wait that never answers
    do
      @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (wr && a == prog_timer_pkg::OFS_CTRL)
      ctrl_m = d[5:0];
  endtask : bus

  task automatic wctl(input logic [5:0] v);
    bus(1'b1, prog_timer_pkg::OFS_CTRL, {26'h0, v});
  endtask : wctl

  // Cycles until the next rising output edge, capped at lim
  task automatic rise(input int lim, output int c);
    c = 0;
    while (timer_out !== 1'b0 && c < lim)
    begin
      @(posedge core_clk);
      c++;
    end
    while (timer_out !== 1'b1 && c < lim)
    begin
      @(posedge core_clk);
      c++;
    end
  endtask : rise

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (95000) @(posedge core_clk);
    failures++;
    final_report;
  end

  initial
  begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    lfsr = lfsr_next(lfsr);
    bus(1'b1, prog_timer_pkg::OFS_STATUS, lfsr);
    bus(1'b1, 4'hC, lfsr);
    bus(1'b0, 4'hC, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b0, prog_timer_pkg::OFS_CTRL, 32'h0);
    check("ctrl", rd, {26'h0, ctrl_m});
    // Clear held with each polarity
    for (int i = 0; i < 2; i++)
    begin
      wctl({3'b011, i[0], 2'b10});
      repeat (40) @(posedge core_clk);
      check("out_in_reset", {31'h0, timer_out}, {31'h0, i[0]});
      bus(1'b0, prog_timer_pkg::OFS_COUNT, 32'h0);
      check("count_in_reset", rd & 32'hFFFF, 32'h0);
      bus(1'b0, prog_timer_pkg::OFS_STATUS, 32'h0);
      check("latch_in_reset", {31'h0, rd[1]}, 32'h0);
      check("reset_flag", {31'h0, rd[2]}, 32'h1);
    end
    // Recycle period of the 8192, 1024 and 256 selects; the 65536 select is not timed here
    for (int s = 0; s < 3; s++)
    begin
      lfsr = lfsr_next(lfsr);
      wctl({3'b001, lfsr[0], s[1:0]});
      rise(40000, n);
      rise(40000, p);
      check("period", p, ratio(s) * OSC);
    end
    // Frozen enable right after a rise stretches the period by its length
    ce <= 1'b0;
    repeat (100) @(posedge core_clk);
    ce <= 1'b1;
    rise(4000, p);
    check("ce_freeze", p, 256 * OSC);
    wctl(6'h1B);
    wctl(6'h0B);
    rise(3000, n);
    check("upper_sel", n, 3000);
    run <= 1'b1;
    wctl(6'h2A);
    rise(4000, n);
    rise(4000, p);
    check("ext_period", p, 256 * 4);
    run <= 1'b0;
    // Single-cycle: one transition, then quiet
    wctl(6'h12);
    wctl(6'h02);
    rise(2000, n);
    check("single_delay", {31'h0, n >= 128 * OSC - 2 && n <= 128 * OSC + 8},
          32'h1);
    rise(1500, n);
    check("single_quiet", n, 1500);
    wctl(6'h0A);
    wctl(6'h02);
    bus(1'b0, prog_timer_pkg::OFS_STATUS, 32'h0);
    check("latch_cleared", {31'h0, rd[1]}, 32'h0);
    // Fresh reset with each strap level; status read in the window
    for (int j = 0; j < 2; j++)
    begin
      strap <= j[0];
      rstn  <= 1'b0;
      repeat (3) @(posedge core_clk);
      rstn  <= 1'b1;
      @(posedge core_clk);
      bus(1'b0, prog_timer_pkg::OFS_STATUS, 32'h0);
      check("por_flag", {31'h0, rd[3]}, {31'h0, ~j[0]});
      check("por_reset", {31'h0, rd[2]}, {31'h0, ~j[0]});
      check("out_after_reset", {31'h0, timer_out}, 32'h0);
    end
    final_report;
  end
endmodule : tb
`default_nettype wire
